// file: uiec_pkg.sv
/*
 * Package for the IN endpoint configuration block: register map, field positions,
 * reset values, response codes and carrier structs.
 * Assumes a single 40 MHz clock domain and an AXI4-Lite register bus.
 */
`default_nettype none

package uiec_pkg;

	// Register byte addresses on the register bus.
	localparam logic [7:0] UIEC_ADDR_CONFIG = 8'h00;
	localparam logic [7:0] UIEC_ADDR_STATUS = 8'h04;

	// Field positions inside the configuration byte.
	localparam int UIEC_BIT_ENABLE     = 7;
	localparam int UIEC_BIT_ISO        = 6;
	localparam int UIEC_BIT_TOGGLE     = 5;
	localparam int UIEC_BIT_DOUBLE_BUF = 4;
	localparam int UIEC_BIT_STALL      = 3;
	localparam int UIEC_BIT_IRQEN      = 2;

	// Values after reset.
	localparam logic [7:0] UIEC_CONFIG_RESET = 8'h00;

	// AXI response codes.
	localparam logic [1:0] UIEC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] UIEC_RESP_SLVERR = 2'h2;

	// Handshake answer given to an IN token.
	typedef enum logic [1:0] {
		UIEC_ANS_NONE,
		UIEC_ANS_DATA,
		UIEC_ANS_NAK,
		UIEC_ANS_STALL
	} uiec_answer_t;

	// Token event from the serial engine toward this endpoint.
	typedef struct packed {
		logic in_token;
		logic setup_token;
		logic data_ready;
	} uiec_token_t;

	// Reply to the serial engine.
	typedef struct packed {
		uiec_answer_t answer;
		logic         data1;
		logic         buf_y;
	} uiec_reply_t;

endpackage : uiec_pkg

`default_nettype wire

// file: uiec_config_reg.sv
/*
 * Configuration byte storage: software fields plus the hardware-owned toggle.
 * Assumes write strobes come from the bus slave in the top module.
 */
`timescale 1ns/1ps
`default_nettype none

module uiec_config_reg
	import uiec_pkg::*;
(
	input  wire logic       clk,        // System clock.
	input  wire logic       resetn,     // Asynchronous reset, active low.
	input  wire logic       wr_en,      // Software write strobe.
	input  wire logic [7:0] wr_data,    // Software write byte.
	input  wire logic       tog_flip,   // Hardware toggle request.
	output var  logic [7:0] cfg         // Stored configuration byte.
);

	logic [7:0] next_cfg;

	// Software writes bits 7:6, 4:2; the toggle only flips by hardware; 1:0 stay zero.
	always_comb begin
		next_cfg = cfg;
		if (wr_en) begin
			next_cfg[7:6] = wr_data[7:6];
			next_cfg[4:2] = wr_data[4:2];
		end
		if (tog_flip) begin
			next_cfg[UIEC_BIT_TOGGLE] = ~cfg[UIEC_BIT_TOGGLE];
		end
		next_cfg[1:0] = 2'h0;
	end

	// Register the byte.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg <= UIEC_CONFIG_RESET;
		end else begin
			cfg <= next_cfg;
		end
	end

	a_toggle_flip: assert property (@(posedge clk) disable iff (!resetn)
		tog_flip |=> cfg[UIEC_BIT_TOGGLE] != $past(cfg[UIEC_BIT_TOGGLE]))
		else $error("Toggle did not flip.");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
		cfg[1:0] == 2'h0)
		else $error("Reserved bits not zero.");

endmodule // uiec_config_reg

`default_nettype wire

// file: uiec_endpoint.sv
/*
 * IN endpoint configuration and answer logic for control, interrupt and bulk use.
 * Assumes tokens and host acks arrive as one-cycle pulses synchronous to clk.
 */
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module uiec_endpoint
	import uiec_pkg::*;
(
	input  wire logic        clk,          // 40 MHz system clock.
	input  wire logic        resetn,       // Asynchronous reset, active low.
	input  wire logic [7:0]  s_axi_awaddr, // Write address.
	input  wire logic        s_axi_awvalid,// Write address valid.
	output var  logic        s_axi_awready,// Write address ready.
	input  wire logic [31:0] s_axi_wdata,  // Write data.
	input  wire logic [3:0]  s_axi_wstrb,  // Write byte strobes.
	input  wire logic        s_axi_wvalid, // Write data valid.
	output var  logic        s_axi_wready, // Write data ready.
	output var  logic [1:0]  s_axi_bresp,  // Write response.
	output var  logic        s_axi_bvalid, // Write response valid.
	input  wire logic        s_axi_bready, // Write response ready.
	input  wire logic [7:0]  s_axi_araddr, // Read address.
	input  wire logic        s_axi_arvalid,// Read address valid.
	output var  logic        s_axi_arready,// Read address ready.
	output var  logic [31:0] s_axi_rdata,  // Read data.
	output var  logic [1:0]  s_axi_rresp,  // Read response.
	output var  logic        s_axi_rvalid, // Read data valid.
	input  wire logic        s_axi_rready, // Read data ready.
	input  wire uiec_token_t tok,          // Token pulses and data-ready level.
	input  wire logic        host_ack,     // Host ACK after our data packet.
	input  wire logic        ep_event,     // Raw endpoint interrupt event.
	output var  uiec_reply_t reply,        // Registered answer to the engine.
	output var  logic        setup_taken,  // Pulse: setup stage received.
	output var  logic        ep_irq        // Gated endpoint interrupt.
);

	logic [7:0]   cfg;
	logic         aw_held, w_held;
	logic [7:0]   aw_addr;
	logic [7:0]   w_byte;
	logic         w_lane;
	logic         next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [7:0]   next_aw_addr, next_w_byte;
	logic         next_w_lane;
	logic [1:0]   next_bresp, next_rresp;
	logic [31:0]  next_rdata;
	logic         cfg_wr;
	logic         in_flight, next_in_flight;
	logic         buf_sel, next_buf_sel;
	logic         tog_flip;
	uiec_reply_t  next_reply;
	logic         next_setup, next_irq;

	// Configuration byte storage.
	uiec_config_reg u_cfg (
		.clk      (clk),
		.resetn   (resetn),
		.wr_en    (cfg_wr),
		.wr_data  (w_byte),
		.tog_flip (tog_flip),
		.cfg      (cfg)
	);

	// Write channel: address and data taken in either order, response after both.
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_byte  = w_byte;
		next_w_lane  = w_lane;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		cfg_wr       = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_w_lane = s_axi_wstrb[0];
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			if (aw_addr == UIEC_ADDR_CONFIG) begin
				cfg_wr     = w_lane;
				next_bresp = UIEC_RESP_OKAY;
			end else if (aw_addr == UIEC_ADDR_STATUS) begin
				next_bresp = UIEC_RESP_OKAY;
			end else begin
				next_bresp = UIEC_RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	// Read channel: one-cycle decode, status shows buffer and in-flight state.
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			if (s_axi_araddr == UIEC_ADDR_CONFIG) begin
				next_rdata = {24'h000000, cfg};
				next_rresp = UIEC_RESP_OKAY;
			end else if (s_axi_araddr == UIEC_ADDR_STATUS) begin
				next_rdata = {30'h0, in_flight, buf_sel};
				next_rresp = UIEC_RESP_OKAY;
			end else begin
				next_rdata = 32'h00000000;
				next_rresp = UIEC_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// Register the bus slave state; readies are low while an answer is pending.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_byte        <= 8'h00;
			w_lane        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= UIEC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= UIEC_RESP_OKAY;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_byte        <= next_w_byte;
			w_lane        <= next_w_lane;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// Token answer: iso gets none first, then stall, then disable, then data or NAK.
	always_comb begin
		next_reply        = reply;
		next_reply.answer = UIEC_ANS_NONE;
		next_in_flight    = in_flight;
		next_buf_sel      = buf_sel;
		tog_flip          = 1'b0;
		next_setup        = tok.setup_token;
		if (tok.in_token && !cfg[UIEC_BIT_ISO]) begin
			if (cfg[UIEC_BIT_STALL]) begin
				next_reply.answer = UIEC_ANS_STALL;
			end else if (!cfg[UIEC_BIT_ENABLE]) begin
				next_reply.answer = UIEC_ANS_NONE;
			end else if (tok.data_ready) begin
				next_reply.answer = UIEC_ANS_DATA;
				next_reply.data1  = cfg[UIEC_BIT_TOGGLE];
				next_reply.buf_y  = buf_sel;
				next_in_flight    = 1'b1;
			end else begin
				next_reply.answer = UIEC_ANS_NAK;
			end
		end else if (tok.setup_token && cfg[UIEC_BIT_STALL]) begin
			next_reply.answer = UIEC_ANS_STALL;
		end
		if (in_flight && host_ack) begin
			tog_flip       = 1'b1;
			// A packet sent in the same cycle as the ack keeps the endpoint in flight.
			next_in_flight = next_reply.answer == UIEC_ANS_DATA;
			next_buf_sel   = cfg[UIEC_BIT_DOUBLE_BUF] ? ~buf_sel : 1'b0;
		end else if (!cfg[UIEC_BIT_DOUBLE_BUF]) begin
			next_buf_sel = 1'b0;
		end
		if (tok.in_token && in_flight && !host_ack) begin
			next_in_flight = next_reply.answer == UIEC_ANS_DATA;
		end
		next_irq = ep_event && cfg[UIEC_BIT_IRQEN];
	end

	// Register the endpoint state and its outputs.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reply       <= '{answer: UIEC_ANS_NONE, data1: 1'b0, buf_y: 1'b0};
			in_flight   <= 1'b0;
			buf_sel     <= 1'b0;
			setup_taken <= 1'b0;
			ep_irq      <= 1'b0;
		end else begin
			reply       <= next_reply;
			in_flight   <= next_in_flight;
			buf_sel     <= next_buf_sel;
			setup_taken <= next_setup;
			ep_irq      <= next_irq;
		end
	end

	a_stall_answer: assert property (@(posedge clk) disable iff (!resetn)
		tok.in_token && cfg[UIEC_BIT_STALL] && !cfg[UIEC_BIT_ISO]
		|=> reply.answer == UIEC_ANS_STALL)
		else $error("Stalled endpoint did not answer STALL.");
	a_disabled_silent: assert property (@(posedge clk) disable iff (!resetn)
		tok.in_token && !cfg[UIEC_BIT_ENABLE] && !cfg[UIEC_BIT_STALL]
		|=> reply.answer == UIEC_ANS_NONE)
		else $error("Disabled endpoint answered.");
	a_pid_select: assert property (@(posedge clk) disable iff (!resetn)
		reply.answer == UIEC_ANS_DATA |-> reply.data1 == $past(cfg[UIEC_BIT_TOGGLE]))
		else $error("Wrong data PID.");
	a_single_buf_x: assert property (@(posedge clk) disable iff (!resetn)
		!cfg[UIEC_BIT_DOUBLE_BUF] |=> !buf_sel)
		else $error("Single buffer mode used Y.");
	a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
		ep_irq |-> $past(cfg[UIEC_BIT_IRQEN]) && $past(ep_event))
		else $error("Interrupt without enable.");
	a_setup_always: assert property (@(posedge clk) disable iff (!resetn)
		tok.setup_token |=> setup_taken)
		else $error("Setup lost.");
	a_iso_no_answer: assert property (@(posedge clk) disable iff (!resetn)
		tok.in_token && cfg[UIEC_BIT_ISO] |=> reply.answer == UIEC_ANS_NONE)
		else $error("Iso endpoint answered in bulk logic.");
	a_ack_toggles: assert property (@(posedge clk) disable iff (!resetn)
		in_flight && host_ack ##2 1'b1
		|-> cfg[UIEC_BIT_TOGGLE] != $past(cfg[UIEC_BIT_TOGGLE], 2))
		else $error("Toggle not flipped after ack.");

	c_data_sent: cover property (@(posedge clk) reply.answer == UIEC_ANS_DATA);
	c_stall_sent: cover property (@(posedge clk) reply.answer == UIEC_ANS_STALL);
	c_buf_y: cover property (@(posedge clk) reply.answer == UIEC_ANS_DATA && reply.buf_y);
	c_irq: cover property (@(posedge clk) ep_irq);

endmodule // uiec_endpoint

`default_nettype wire

// file: uiec_host_model.sv
/*
 * Host model: issues IN tokens on request and acknowledges DATA packets.
 * Assumes the endpoint answers one cycle after each token.
 */
`timescale 1ns/1ps
`default_nettype none

module uiec_host_model
	import uiec_pkg::*;
(
	input  wire logic        clk,      // System clock.
	input  wire logic        resetn,   // Reset, active low.
	input  wire logic        send,     // Pulse: issue one IN token.
	input  wire logic        ack_en,   // Acknowledge data packets when high.
	input  wire logic [1:0]  ack_dly,  // Extra cycles before the ACK.
	input  wire uiec_reply_t reply,    // Endpoint answer.
	output var  logic        in_token, // IN token pulse.
	output var  logic        host_ack  // ACK pulse after a good packet.
);
	logic [2:0] wait_n;
	logic       pend;

	// Tokens follow requests; a DATA answer is acknowledged after a delay.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_token <= 1'b0;
			host_ack <= 1'b0;
			pend     <= 1'b0;
			wait_n   <= 3'h0;
		end else begin
			in_token <= send;
			host_ack <= 1'b0;
			if (reply.answer == UIEC_ANS_DATA && ack_en) begin
				pend   <= 1'b1;
				wait_n <= {1'b0, ack_dly};
			end else if (pend && wait_n == 3'h0) begin
				host_ack <= 1'b1;
				pend     <= 1'b0;
			end else if (pend) begin
				wait_n <= wait_n - 3'h1;
			end
		end
	end
endmodule // uiec_host_model

`default_nettype wire

// file: uiec_endpoint_tb.sv
/*
 * Self-checking bench for the IN endpoint block.
 * Assumes the host model and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR %0t: got %0h exp %0h", $time, (a), (e)); end end

module uiec_endpoint_tb;
	import uiec_pkg::*;
	logic        clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, setup = 0, ready = 0, ep_event = 0;
	logic        send = 0, ack_en = 1, tok_d = 0, st_d = 0, ev_d = 0, ev_e = 0;
	logic        tog = 0, by = 0;
	logic        awready, wready, bvalid, arready, rvalid, setup_taken, ep_irq;
	logic        host_ack, in_token;
	logic [7:0]  awaddr = 0, araddr = 0, cfg = 0;
	logic [1:0]  dly = 0, bresp, rresp;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  ea, strb = 4'hF;
	logic [33:0] exp_q[$];
	logic [3:0]  ans_q[$];
	logic [7:0]  modes[2] = '{8'h80, 8'h90};
	uiec_reply_t reply;
	uiec_token_t tok;
	int          miscompares = 0, n_checks = 0;

	assign tok = {in_token, setup, ready};

	// Free-running clock.
	always #12.5 clk = ~clk;

	uiec_endpoint dut_u (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tok(tok), .host_ack(host_ack), .ep_event(ep_event),
		.reply(reply), .setup_taken(setup_taken), .ep_irq(ep_irq));

	uiec_host_model host_u (.clk(clk), .resetn(resetn), .send(send), .ack_en(ack_en),
		.ack_dly(dly), .reply(reply), .in_token(in_token), .host_ack(host_ack));

	task automatic end_sim;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		int i;
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		if (i == 40) begin miscompares++; end_sim(); end
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		int i;
		exp_q.push_back({UIEC_RESP_OKAY, e});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		if (i == 40) begin miscompares++; end_sim(); end
		cyc(1);
	endtask

	// Config write with random reserved and toggle bits; config read back.
	task automatic wc(input logic [7:0] d);
		wr(UIEC_ADDR_CONFIG, d | (8'($urandom) & 8'h23), UIEC_RESP_OKAY);
		cfg = d;
	endtask

	task automatic rc;
		rd(UIEC_ADDR_CONFIG, {24'h0, (cfg & 8'hDC) | {2'h0, tog, 5'h0}});
	endtask

	// One IN token; the expected answer is noted before it is sent.
	task automatic tk(input logic [1:0] a);
		ans_q.push_back({a, tog, by});
		dly <= 2'($urandom_range(3));
		send <= 1;
		cyc(1);
		send <= 0;
		cyc(10);
		if (a == 2'h1 && ack_en) begin
			tog = ~tog;
			if (cfg[4]) by = ~by;
		end
	endtask

	task automatic irq(input logic e);
		ev_e <= e;
		ep_event <= 1;
		cyc(1);
		ep_event <= 0;
		cyc(2);
	endtask

	// Output watcher: each bus and token result is compared with the oldest note.
	always @(posedge clk) begin
		tok_d <= in_token;
		st_d <= setup;
		ev_d <= ep_event;
		if (bvalid && bready) `CHK({bresp, 32'h0}, exp_q.pop_front())
		if (rvalid && rready) `CHK({rresp, rdata}, exp_q.pop_front())
		if (tok_d) begin
			ea = ans_q.pop_front();
			`CHK(reply.answer, ea[3:2])
			if (ea[3:2] == 2'h1) `CHK({reply.data1, reply.buf_y}, ea[1:0])
		end
		if (st_d) `CHK(setup_taken, 1'b1)
		if (ev_d) `CHK(ep_irq, ev_e)
	end

	// Main sequence.
	initial begin
		void'($urandom(32'h6fe4));
		cyc(12);
		resetn <= 1;
		cyc(3);
		rc();
		rd(UIEC_ADDR_STATUS, 32'h0);
		wr(8'h08, 8'hFF, UIEC_RESP_SLVERR);
		rc();
		ready <= 1;
		setup <= 1;
		cyc(1);
		setup <= 0;
		cyc(2);
		tk(2'h0);
		foreach (modes[m]) begin
			wc(modes[m]);
			for (int i = 0; i < 4; i++) begin
				ack_en <= (i != 1);
				cyc(1);
				tk(2'h1);
				if (i == 1) rd(UIEC_ADDR_STATUS, {30'h0, 1'b1, by});
			end
			rd(UIEC_ADDR_STATUS, {31'h0, by});
			rc();
		end
		ready <= 0;
		tk(2'h2);
		ready <= 1;
		wc(8'h88);
		tk(2'h3);
		wc(8'h08);
		tk(2'h3);
		wc(8'hC0);
		tk(2'h0);
		wc(8'h84);
		irq(1'b1);
		wc(8'h80);
		irq(1'b0);
		strb <= 4'hE;
		wr(UIEC_ADDR_CONFIG, 8'h00, UIEC_RESP_OKAY);
		strb <= 4'hF;
		rc();
		end_sim();
	end
endmodule // uiec_endpoint_tb

`default_nettype wire
